//--- verilog/gri_pkg.sv
// constants for the angular-rate interrupt generator
// assumes an 8-bit register port with byte offsets as printed
package gri_pkg;
  localparam logic [7:0] OFS_CFG      = 8'h30;
  localparam logic [7:0] OFS_PITCH_H  = 8'h31;
  localparam logic [7:0] OFS_PITCH_L  = 8'h32;
  localparam logic [7:0] OFS_ROLL_H   = 8'h33;
  localparam logic [7:0] OFS_ROLL_L   = 8'h34;
  localparam logic [7:0] OFS_YAW_H    = 8'h35;
  localparam logic [7:0] OFS_YAW_L    = 8'h36;
  localparam logic [7:0] OFS_DUR      = 8'h37;
  localparam logic [7:0] OFS_STATUS   = 8'h38;
  localparam logic [7:0] OFS_MASK     = 8'h39;
  localparam logic [7:0] OFS_SOURCE   = 8'h3a;
  // register field positions and reset values
  localparam int CFG_COMBINE = 7;
  localparam int CFG_LATCH   = 6;
  localparam int THS_DECR    = 7;
  localparam int DUR_WAIT    = 7;
  localparam int STAT_EVENT  = 0;
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] THS_RST   = 8'h00;
  localparam logic [7:0] DUR_RST   = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
endpackage

//--- verilog/gri_rate_irq.sv
// angular-rate interrupt generator with register port and interrupt
// assumes sample_valid is a one-cycle pulse in ref_clk domain with new axis data
// and that the three rate inputs are steady in the cycle where it is high
// Behaviour
// - combine select: 0 OR, 1 AND
// - latch holds request until source read
// - high event when rate above threshold
// - low event when rate below threshold
// - signed 15-bit threshold per axis, reset zero
// - pitch high top bit: reset or decrement
// - event recognized after duration samples persist
// - wait clear: release on first lapsed sample
// - wait set: release after duration samples
// - duration counts output sample rate samples
// - status flag sets on a rising request and sticks until written one
`timescale 1ns/1ps
module gri_rate_irq
  import gri_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         sample_valid,
  input  wire logic [W-1:0] pitch_rate,
  input  wire logic [W-1:0] roll_rate,
  input  wire logic [W-1:0] yaw_rate,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [7:0]        reg_rdata,
  output logic              rate_event_flag,
  output logic              irq
);
  // register map, byte wide:
  //   0x30 config: combine, latch, six event enables
  //   0x31/0x32 pitch limit high/low, high bit 7 picks counter mode
  //   0x33/0x34 roll limit high/low, high bit 7 kept zero by software
  //   0x35/0x36 yaw limit high/low, high bit 7 kept zero by software
  //   0x37 duration: wait bit and seven-bit count
  //   0x38 status: bit 0 sticky, write one to clear
  //   0x39 mask: bit 0 lets status reach the interrupt
  //   0x3a source: request and the six event bits of the last hit
  // the source layout matches the enable layout, so software can mask
  // one with the other directly
  // unmapped offsets read zero and ignore writes

  // one-hot generator state: waiting for a condition, or holding an event
  typedef enum logic [1:0] {
    GRI_IDLE   = 2'b01,
    GRI_ACTIVE = 2'b10
  } gri_state_t;

  // configuration registers, each beside its next value
  logic [7:0]  cfg_q;
  logic [7:0]  cfg_d;
  logic [7:0]  dur_q;
  logic [7:0]  dur_d;
  logic [7:0]  mask_q;
  logic [7:0]  mask_d;
  // threshold bytes, index 0 pitch, 1 roll, 2 yaw
  logic [7:0]  ths_h_q [3];
  logic [7:0]  ths_h_d [3];
  logic [7:0]  ths_l_q [3];
  logic [7:0]  ths_l_d [3];
  // generator bookkeeping
  gri_state_t  state_q;
  gri_state_t  state_d;
  logic [5:0]  src_q;
  logic [5:0]  src_d;
  logic [6:0]  cnt_q;
  logic [6:0]  cnt_d;
  logic        act_d;
  // request, sticky status, interrupt and read data
  logic        req_q;
  logic        req_d;
  logic        stat_q;
  logic        stat_d;
  logic        irq_q;
  logic        irq_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  // live compare results and their combination
  logic [1:0]  axis_hit [3];
  logic [5:0]  hit;
  logic        cond;

  // 15-bit threshold sign-extended to sample width; bit 7 of the high
  // byte is not part of the value (pitch: counter mode, others: zero)
  function automatic logic signed [W-1:0] ths_val(input logic [7:0] h, input logic [7:0] l);
    logic [14:0] t;
    t = {h[6:0], l};
    ths_val = W'(signed'(t));
  endfunction

  // and mode needs every enabled source; with none enabled it never
  // fires, so a blank config cannot raise a spurious request
  function automatic logic all_hit(input logic [5:0] h, input logic [5:0] en);
    all_hit = (|en) && ((h | ~en) == 6'h3f);
  endfunction

  // per-axis compare, strict on both sides: a rate equal to the limit is
  // neither high nor low, so both events of one axis never fire together
  // limitation: a limit only spans 15 bits, so the widest rates of a
  // 16-bit sample always count as high or low once enabled
  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [W-1:0] rate_s;
    logic signed [W-1:0] limit_s;
    logic                hi_s;
    logic                lo_s;
    if (a == 0) begin : g_pitch
      assign rate_s = signed'(pitch_rate);
    end else if (a == 1) begin : g_roll
      assign rate_s = signed'(roll_rate);
    end else begin : g_yaw
      assign rate_s = signed'(yaw_rate);
    end
    assign limit_s = ths_val(ths_h_q[a], ths_l_q[a]);
    // enable bits sit at 2a+1 (high) and 2a (low) of the config byte
    assign hi_s = cfg_q[2*a+1] && (rate_s > limit_s);
    assign lo_s = cfg_q[2*a]   && (rate_s < limit_s);
    assign axis_hit[a] = {hi_s, lo_s};
  end

  // gather the axes into the source layout {yaw, roll, pitch}
  assign hit = {axis_hit[2], axis_hit[1], axis_hit[0]};

  // or mode fires on any enabled event, and mode only on all of them
  always_comb begin
    if (cfg_q[CFG_COMBINE]) begin
      cond = all_hit(hit, cfg_q[5:0]);
    end else begin
      cond = |hit;
    end
  end

  // duration counter and generator state, stepped only on a new sample so
  // that counts are in output sample rate steps whatever the clock
  // limitation: the count is seven bits, so a slow sample rate gives the
  // longest hold; nothing here stretches it further
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    src_d   = src_q;
    if (sample_valid) begin
      unique case (state_q)
        GRI_IDLE: begin
          if (cond) begin
            // the condition must have held for the full count first
            if (cnt_q >= dur_q[6:0]) begin
              state_d = GRI_ACTIVE;
              cnt_d   = 7'h00;
              src_d   = hit;
            end else begin
              cnt_d = cnt_q + 7'h01;
            end
          end else if (ths_h_q[0][THS_DECR] && cnt_q != 7'h00) begin
            // decrement mode forgives a short lapse instead of restarting
            cnt_d = cnt_q - 7'h01;
          end else begin
            cnt_d = 7'h00;
          end
        end
        GRI_ACTIVE: begin
          if (cond) begin
            // still true: restart the exit count, refresh the source
            cnt_d = 7'h00;
            src_d = hit;
          end else if (!dur_q[DUR_WAIT]) begin
            // no wait: drop on the first lapsed sample
            state_d = GRI_IDLE;
            cnt_d   = 7'h00;
          end else if (cnt_q + 7'h01 >= dur_q[6:0]) begin
            // wait: drop once the lapse has lasted the duration count
            state_d = GRI_IDLE;
            cnt_d   = 7'h00;
          end else begin
            cnt_d = cnt_q + 7'h01;
          end
        end
        default: begin
          // an illegal code falls back to idle with a clean count
          state_d = GRI_IDLE;
          cnt_d   = 7'h00;
        end
      endcase
    end
  end

  // request follows the state the generator moves into at this edge
  assign act_d = (state_d == GRI_ACTIVE);

  // register port, request latch, sticky status and interrupt
  // the status bit sets on a rising request and a same-cycle clear loses,
  // so an event arriving while software clears is never missed
  // reading the source releases a latched request; a live event keeps it
  always_comb begin
    logic rd_src;
    rd_src  = reg_rd && reg_addr == OFS_SOURCE;
    cfg_d   = cfg_q;
    dur_d   = dur_q;
    mask_d  = mask_q;
    ths_h_d = ths_h_q;
    ths_l_d = ths_l_q;
    rdata_d = 8'h00;
    // latched request cleared by reading source; new event wins
    if (cfg_q[CFG_LATCH])
      req_d = act_d | (req_q & ~rd_src);
    else
      req_d = act_d;
    stat_d = stat_q;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CFG:     cfg_d      = reg_wdata;
        OFS_PITCH_H: ths_h_d[0] = reg_wdata;
        OFS_PITCH_L: ths_l_d[0] = reg_wdata;
        OFS_ROLL_H:  ths_h_d[1] = reg_wdata;
        OFS_ROLL_L:  ths_l_d[1] = reg_wdata;
        OFS_YAW_H:   ths_h_d[2] = reg_wdata;
        OFS_YAW_L:   ths_l_d[2] = reg_wdata;
        OFS_DUR:     dur_d      = reg_wdata;
        OFS_MASK:    mask_d     = reg_wdata;
        OFS_STATUS:  if (reg_wdata[STAT_EVENT]) stat_d = 1'b0;
        default:     ;
      endcase
    end
    if (req_d && !req_q)
      stat_d = 1'b1;                                 // set beats clear
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CFG:     rdata_d = cfg_q;
        OFS_PITCH_H: rdata_d = ths_h_q[0];
        OFS_PITCH_L: rdata_d = ths_l_q[0];
        OFS_ROLL_H:  rdata_d = ths_h_q[1];
        OFS_ROLL_L:  rdata_d = ths_l_q[1];
        OFS_YAW_H:   rdata_d = ths_h_q[2];
        OFS_YAW_L:   rdata_d = ths_l_q[2];
        OFS_DUR:     rdata_d = dur_q;
        OFS_STATUS:  rdata_d = {7'h00, stat_q};
        OFS_MASK:    rdata_d = mask_q;
        OFS_SOURCE:  rdata_d = {1'b0, req_q, src_q};
        default:     rdata_d = 8'h00;
      endcase
    end
    irq_d = stat_d & mask_d[STAT_EVENT];
  end

  // all state registers; reset clears configuration to zero so the
  // generator starts with every event disabled and no request pending
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q   <= CFG_RST;
      dur_q   <= DUR_RST;
      mask_q  <= MASK_RST;
      ths_h_q <= '{THS_RST, THS_RST, THS_RST};
      ths_l_q <= '{THS_RST, THS_RST, THS_RST};
      src_q   <= 6'h00;
      cnt_q   <= 7'h00;
      state_q <= GRI_IDLE;
      req_q   <= 1'b0;
      stat_q  <= 1'b0;
      irq_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      cfg_q   <= cfg_d;
      dur_q   <= dur_d;
      mask_q  <= mask_d;
      ths_h_q <= ths_h_d;
      ths_l_q <= ths_l_d;
      src_q   <= src_d;
      cnt_q   <= cnt_d;
      state_q <= state_d;
      req_q   <= req_d;
      stat_q  <= stat_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs come straight from their flip-flops
  assign reg_rdata       = rdata_q;
  assign rate_event_flag = req_q;
  assign irq             = irq_q;
endmodule

//--- bench/gri_rate_irq_props.sv
// port checks for the rate interrupt block
// assumes it is bound to gri_rate_irq
`timescale 1ns/1ps
module gri_chk import gri_pkg::*; (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       sample_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       rate_event_flag,
  input wire logic       irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // a clear with no sample beside it, since a new event wins
  sequence clr_s; reg_wr && reg_addr == OFS_STATUS && reg_wdata[0] && !sample_valid; endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("idle rdata");
  rdata_unmap_a: assert property (reg_rd && reg_addr < OFS_CFG |=> reg_rdata == 8'h00)
    else $error("unmapped rdata");
  flag_step_a: assert property (!sample_valid && !(reg_rd && reg_addr == OFS_SOURCE)
    && !(reg_wr && reg_addr == OFS_CFG) |=> $stable(rate_event_flag)) else $error("flag moved");
  irq_cause_a: assert property ($rose(irq) |-> rate_event_flag || $past(reg_wr))
    else $error("irq cause");
  irq_clear_a: assert property (clr_s |=> !irq)
    else $error("irq not cleared");
  irq_mask_a: assert property (reg_wr && reg_addr == OFS_MASK && !reg_wdata[0] |=> !irq)
    else $error("irq not masked");
  irq_hold_a: assert property (irq && !reg_wr |=> irq)
    else $error("irq dropped");
  stat_read_a: assert property (irq && reg_rd && reg_addr == OFS_STATUS
    |=> reg_rdata[STAT_EVENT]) else $error("status bit");
endmodule
bind gri_rate_irq gri_chk u_chk (.ref_clk, .nrst, .sample_valid, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .rate_event_flag, .irq);

//--- bench/tb_gri_rate_irq.sv
// random-threshold bench for the rate interrupt block
// assumes gri_chk binds itself to uut
`timescale 1ns/1ps
module tb_gri_rate_irq import gri_pkg::*; ;
  logic        ref_clk = 0, nrst = 0, sample_valid = 0, reg_wr = 0, reg_rd = 0;
  logic        rate_event_flag, irq;
  logic [15:0] hi, lo, v, w, pitch_rate = 0, roll_rate = 0, yaw_rate = 0;
  logic [14:0] t;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
  int          error_cnt = 0, checks_done = 0, seed = 32'h656c00dd;
  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;
  gri_rate_irq uut (.ref_clk, .nrst, .sample_valid, .pitch_rate, .roll_rate, .yaw_rate,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rate_event_flag, .irq);
  task automatic chk(logic [7:0] s, e, string n);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(logic wr, logic [7:0] a, d);
    @(posedge ref_clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
    @(posedge ref_clk) {reg_wr, reg_rd} <= 2'b00;
    #1 if (!wr) chk(reg_rdata, d, "rdata");
  endtask
  task automatic smp(logic [15:0] x, y, z, logic e);
    @(posedge ref_clk) {sample_valid, pitch_rate, roll_rate, yaw_rate} <= {1'b1, x, y, z};
    @(posedge ref_clk) sample_valid <= 0;
    #1 chk(8'(rate_event_flag), 8'(e), "flag");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // reset, registers, events, then the interrupt
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1;
    for (int a = 'h2f; a < 'h3c; a++) bus(0, 8'(a), 8'h00);
    t = 15'($random(seed));
    hi = {t[14], t} + 16'($random(seed) & 7) + 16'h1;
    lo = {t[14], t} - 16'($random(seed) & 7) - 16'h1;
    for (int o = 'h31; o < 'h37; o += 2) begin
      bus(1, 8'(o), {1'b0, t[14:8]});
      bus(1, 8'(o + 1), t[7:0]);
    end
    bus(0, OFS_YAW_H, {1'b0, t[14:8]});
    for (int i = 0; i < 6; i++) begin
      bus(1, OFS_CFG, 8'(1 << i));
      v = i[0] ? hi : lo;
      w = hi ^ lo ^ v;
      smp(i < 2 ? v : w, i / 2 == 1 ? v : w, i > 3 ? v : w, 1);
      smp(w, w, w, 0);
    end
    bus(1, OFS_CFG, 8'h8a);
    smp(hi, lo, lo, 0);
    smp(hi, hi, lo, 1);
    bus(1, OFS_CFG, 8'h02);
    smp(lo, lo, lo, 0);
    bus(1, OFS_DUR, 8'h03);
    for (int k = 0; k < 5; k++) smp(k < 4 ? hi : lo, lo, lo, k == 3);
    bus(1, OFS_DUR, 8'h82);
    smp(lo, lo, lo, 0);
    for (int k = 0; k < 5; k++) smp(k < 3 ? hi : lo, lo, lo, k inside {2, 3});
    bus(1, OFS_DUR, 8'h03);
    for (int m = 0; m < 2; m++) begin
      smp(lo, lo, lo, 0);
      bus(1, OFS_PITCH_H, {m[0], t[14:8]});
      for (int k = 0; k < 6; k++) smp(k == 2 ? lo : hi, lo, lo, m && k == 5);
    end
    smp(lo, lo, lo, 0);
    bus(1, OFS_DUR, 8'h00);
    bus(1, OFS_CFG, 8'h42);
    bus(1, OFS_STATUS, 8'h01);
    bus(1, OFS_MASK, 8'h01);
    smp(hi, lo, lo, 1);
    smp(lo, lo, lo, 1);
    chk(8'(irq), 8'h01, "irq");
    bus(0, OFS_STATUS, 8'h01);
    bus(0, OFS_SOURCE, 8'h42);
    chk(8'(rate_event_flag), 8'h00, "flag");
    bus(1, OFS_MASK, 8'h00);
    chk(8'(irq), 8'h00, "irq");
    bus(1, OFS_MASK, 8'h01);
    bus(1, OFS_STATUS, 8'h01);
    chk(8'(irq), 8'h00, "irq");
    summarize;
  end
  // a hang ends the run as a failure
  initial begin
    #1ms;
    error_cnt++;
    summarize;
  end
endmodule
